// ### core/sos_supervisor.sv
// sos_supervisor: safety switching output supervisor of a laser scanner.
// assumes the optical core reports zone hits per evaluated set, and that
// the output test pulse checker and fault sources are outside.
// Behaviour
// - active zone set follows the present control input pattern
// - each set has one safety zone and at most two warning zones
// - selection uses 6 inputs basic, 8 inputs extended connector
// - up to 20 sets basic, 70 sets extended
// - set change has no overlap; old set stops, new one starts
// - automatic start: outputs on when wiring good, no fault, zone free
// - violated safety zone drives safety outputs off
// - manual restart needs 80 ms since last switch off
// - restart only after press of 0.5 s to 4.5 s, on release
// - presses outside the window are ignored, outputs stay off
// - start input never leaves error state; reset needed
// - output test pulse faults while on enter error state
// - manual reset needs reset input held at least 500 ms
// - automatic reset attempts recovery 10 s after error
// - over 5 interface faults in 15 min disable automatic reset
// - feedback must open within 350 ms after outputs on
// - feedback must close within 100 ms after outputs off
// - feedback checked at each switching and before restart
// - feedback monitoring only for output pairs 1 and 2, if enabled
// - interference code sets cycle time 30 to 31.5 ms
// - basic connector alarm shows window dirty or fault
// - rest condition suspends zones but accepts wake command
// - warning outputs follow warning zones with configurable level
`timescale 1ns/10ps
module sos_supervisor
	import sos_pkg::*;
#(
	parameter int unsigned AUTO_RESET_CYCLES = AUTO_RESET_CYC,
	parameter int unsigned PRESS_MAX_CYCLES = PRESS_MAX_CYC,
	parameter longint unsigned FAULT_WINDOW_CYCLES = FAULT_WINDOW_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// configuration
	input wire sos_cfg_s cfg_i,
	input wire logic [SETS_EXT-1:0][SEL_IN_EXT-1:0] set_pattern_i,
	input wire logic [SETS_EXT-1:0] set_valid_i,
	// control inputs and buttons
	input wire logic [SEL_IN_EXT-1:0] ctrl_in_i,
	input wire logic start_btn_i,
	input wire logic reset_btn_i,
	input wire logic rest_req_i,
	// zone evaluation from the optical core
	input wire sos_zone_s zone_i,
	input wire logic zone_valid_i,
	// health
	input wire logic wiring_ok_i,
	input wire logic fault_i,
	input wire logic test_pulse_fault_i,
	input wire logic interface_fault_code_i,
	input wire logic window_dirty_warning_i,
	input wire logic [1:0] contactor_feedback_monitor_i,
	// outputs
	output logic [1:0] safety_switch_output_o,
	output logic [WARN_MAX-1:0] warn_o,
	output logic alarm_o,
	output logic [SET_W-1:0] active_set_o,
	output logic set_error_o,
	output logic cycle_tick_o,
	output logic auto_reset_lock_o,
	output logic [2:0] state_o
);
	// ==========================================================
	// helpers
	function automatic logic [SET_W-1:0] find_set(
		input logic [SEL_IN_EXT-1:0] pat, input logic ext);
		logic [SEL_IN_EXT-1:0] m;
		find_set = SET_NONE;
		m = ext ? '1 : SEL_IN_EXT'(8'h3f);
		for (int i = SETS_EXT - 1; i >= 0; i--) begin
			if (set_valid_i[i] && (ext || i < SETS_BASIC) &&
				((set_pattern_i[i] & m) == (pat & m)))
				find_set = SET_W'(i);
		end
	endfunction

	function automatic logic over(input logic [CNT_W-1:0] c,
		input int unsigned lim);
		over = c >= CNT_W'(lim);
	endfunction

	// ==========================================================
	// pushbuttons
	logic start_rel;
	logic [CNT_W-1:0] start_len, rst_hold;

	sos_press_timer u_start (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .button_i(start_btn_i),
		.level_o(), .hold_o(), .release_o(start_rel),
		.length_o(start_len)
	);
	sos_press_timer u_reset (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .button_i(reset_btn_i),
		.level_o(), .hold_o(rst_hold), .release_o(),
		.length_o()
	);

	logic start_ok;
	assign start_ok = start_rel && over(start_len, PRESS_MIN_CYC) &&
		(start_len <= CNT_W'(PRESS_MAX_CYCLES));

	// ==========================================================
	// zone set selection and cycle timing
	logic [SET_W-1:0] set_reg, set_next;
	logic trans_reg, trans_next;
	logic [CNT_W-1:0] cyc_reg, cyc_next;
	logic tick_reg, tick_next;
	logic [SET_W-1:0] want;
	logic [CNT_W-1:0] cyc_len;

	assign want = find_set(ctrl_in_i, cfg_i.ext_conn);
	assign cyc_len = CNT_W'(CYCLE_BASE_CYC) +
		CNT_W'(CYCLE_STEP_CYC) * CNT_W'(cfg_i.code);

	// on a change the old set is dropped at once; the new set waits for
	// its first own evaluation, trading one cycle of uptime for no overlap
	always_comb begin
		set_next = set_reg;
		trans_next = trans_reg;
		cyc_next = cyc_reg + CNT_W'(1);
		tick_next = 1'b0;
		if (cyc_reg >= cyc_len - CNT_W'(1)) begin
			cyc_next = '0;
			tick_next = 1'b1;
		end
		if (want != set_reg) begin
			set_next = want;
			trans_next = 1'b1;
		end else if (zone_valid_i) begin
			trans_next = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			set_reg <= SET_NONE;
			trans_reg <= 1'b1;
			cyc_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			set_reg <= set_next;
			trans_reg <= trans_next;
			cyc_reg <= cyc_next;
			tick_reg <= tick_next;
		end
	end

	// ==========================================================
	// main state, timers, feedback checks, fault history
	sos_state_e st_reg, st_next;
	logic [CNT_W-1:0] tmr_reg, tmr_next; // time since last entry to off or error
	logic [CNT_W-1:0] fb_reg, fb_next; // feedback settle timer
	logic fb_pend_reg, fb_pend_next;
	logic [2:0] nfault_reg, nfault_next;
	logic [WIN_W-1:0] win_reg, win_next;
	logic lock_reg, lock_next;
	logic boot_reg, boot_next;
	logic [1:0] fb_used;
	logic fb_open, fb_closed, zone_free, healthy, fb_err, err_in;

	assign fb_used = {cfg_i.fb_en2, cfg_i.fb_en1};
	assign fb_open = &(contactor_feedback_monitor_i | ~fb_used);
	assign fb_closed = &(~contactor_feedback_monitor_i | ~fb_used);
	// a pending set change counts as not free, so the outputs drop on the
	// same edge as the set switch instead of one cycle after it
	assign zone_free = !zone_i.safety_hit && !trans_reg &&
		set_reg != SET_NONE && want == set_reg;
	assign healthy = wiring_ok_i && !fault_i;
	// feedback must change within its window after each switching
	assign fb_err = fb_pend_reg && ((st_reg == SOS_ON) ?
		over(fb_reg, FB_OPEN_CYC) : over(fb_reg, FB_CLOSE_CYC));
	assign err_in = fault_i || interface_fault_code_i || fb_err ||
		(st_reg == SOS_ON && test_pulse_fault_i);

	always_comb begin
		st_next = st_reg;
		tmr_next = tmr_reg;
		if (tmr_reg != '1)
			tmr_next = tmr_reg + CNT_W'(1);
		fb_next = fb_reg + CNT_W'(1);
		fb_pend_next = fb_pend_reg;
		nfault_next = nfault_reg;
		win_next = win_reg;
		lock_next = lock_reg;
		boot_next = boot_reg;
		// fault window restarts with the first counted fault
		if (nfault_reg != 3'h0) begin
			win_next = win_reg + WIN_W'(1);
			if (win_reg >= WIN_W'(FAULT_WINDOW_CYCLES)) begin
				nfault_next = 3'h0;
				win_next = '0;
			end
		end
		if (fb_pend_reg && ((st_reg == SOS_ON) ? fb_open : fb_closed))
			fb_pend_next = 1'b0;
		unique case (st_reg)
			SOS_OFF: begin
				if (rest_req_i) begin
					st_next = SOS_REST;
				end else if (err_in) begin
					st_next = SOS_ERR;
					tmr_next = '0;
				end else if (healthy && zone_free && fb_closed &&
					!fb_pend_reg &&
					((cfg_i.auto_start || boot_reg) ? 1'b1 :
					(over(tmr_reg, RESTART_GAP_CYC) && start_ok))) begin
					st_next = SOS_ON;
					fb_pend_next = |fb_used;
					fb_next = '0;
					boot_next = 1'b0;
				end
			end
			SOS_ON: begin
				if (err_in || rest_req_i || !zone_free) begin
					st_next = err_in ? SOS_ERR :
						(rest_req_i ? SOS_REST : SOS_OFF);
					tmr_next = '0;
					fb_pend_next = |fb_used;
					fb_next = '0;
				end
			end
			SOS_REST: begin
				// zones ignored here; only the wake command is watched
				if (!rest_req_i) begin
					st_next = SOS_OFF;
					tmr_next = '0;
				end
			end
			SOS_ERR: begin
				// the start button is not looked at in this state
				if (healthy && !err_in &&
					(over(rst_hold, RESET_HOLD_CYC) ||
					(cfg_i.auto_reset_en && !lock_reg &&
					over(tmr_reg, AUTO_RESET_CYCLES)))) begin
					st_next = SOS_OFF;
					tmr_next = '0;
					fb_pend_next = 1'b0;
				end
			end
			default: st_next = SOS_ERR;
		endcase
		if (st_reg != SOS_ERR && st_next == SOS_ERR &&
			interface_fault_code_i) begin
			if (nfault_reg == 3'(FAULT_LIMIT))
				lock_next = 1'b1;
			else
				nfault_next = nfault_reg + 3'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			st_reg <= SOS_OFF;
			tmr_reg <= '0;
			fb_reg <= '0;
			fb_pend_reg <= 1'b0;
			nfault_reg <= 3'h0;
			win_reg <= '0;
			lock_reg <= 1'b0;
			boot_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			fb_reg <= fb_next;
			fb_pend_reg <= fb_pend_next;
			nfault_reg <= nfault_next;
			win_reg <= win_next;
			lock_reg <= lock_next;
			boot_reg <= boot_next;
		end
	end

	// ==========================================================
	// output registers
	logic [1:0] out_reg, out_next;
	logic [WARN_MAX-1:0] warn_reg, warn_next;
	logic alarm_reg, alarm_next;

	always_comb begin
		// both channels of the pair always carry the same command
		out_next = (st_next == SOS_ON) ? 2'h3 : 2'h0;
		for (int w = 0; w < WARN_MAX; w++) begin
			// unused warning zones stay at their inactive level
			warn_next[w] = cfg_i.warn_act_high[w] ~^
				(zone_i.warn_hit[w] && zone_i.warn_used[w] &&
				st_reg != SOS_REST && !trans_reg && set_reg != SET_NONE);
		end
		alarm_next = !cfg_i.ext_conn && (cfg_i.alarm_sel ?
			(st_reg == SOS_ERR) : window_dirty_warning_i);
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			out_reg <= 2'h0;
			warn_reg <= '0;
			alarm_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			warn_reg <= warn_next;
			alarm_reg <= alarm_next;
		end
	end

	assign safety_switch_output_o = out_reg;
	assign warn_o = warn_reg;
	assign alarm_o = alarm_reg;
	assign active_set_o = set_reg;
	assign set_error_o = (set_reg == SET_NONE);
	assign cycle_tick_o = tick_reg;
	assign auto_reset_lock_o = lock_reg;
	assign state_o = st_reg;
endmodule

// ### core/sos_pkg.sv
// sos_pkg: constants and types for the safety output supervisor.
// assumes a 20 MHz clock; all time figures are converted to cycle counts here.
package sos_pkg;
	// ==========================================================
	// clock and times
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned RESTART_GAP_MS = 80;
	localparam int unsigned PRESS_MIN_MS = 500;
	localparam int unsigned PRESS_MAX_MS = 4500;
	localparam int unsigned RESET_HOLD_MS = 500;
	localparam int unsigned AUTO_RESET_MS = 10000;
	localparam int unsigned FAULT_WINDOW_MIN = 15;
	localparam int unsigned FB_OPEN_MS = 350;
	localparam int unsigned FB_CLOSE_MS = 100;
	localparam int unsigned DEBOUNCE_US = 1000;
	localparam int unsigned CYCLE_BASE_US = 30000;
	localparam int unsigned CYCLE_STEP_US = 500;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	// least times round up (exact here), longest times round down
	localparam int unsigned RESTART_GAP_CYC = RESTART_GAP_MS * CYC_PER_MS;
	localparam int unsigned PRESS_MIN_CYC = PRESS_MIN_MS * CYC_PER_MS;
	localparam int unsigned PRESS_MAX_CYC = PRESS_MAX_MS * CYC_PER_MS;
	localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
	localparam int unsigned AUTO_RESET_CYC = AUTO_RESET_MS * CYC_PER_MS;
	localparam longint unsigned FAULT_WINDOW_CYC =
		64'(FAULT_WINDOW_MIN) * 64'd60 * 64'(CLK_HZ);
	localparam int unsigned FB_OPEN_CYC = FB_OPEN_MS * CYC_PER_MS;
	localparam int unsigned FB_CLOSE_CYC = FB_CLOSE_MS * CYC_PER_MS;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CYC_PER_US;
	localparam int unsigned CYCLE_BASE_CYC = CYCLE_BASE_US * CYC_PER_US;
	localparam int unsigned CYCLE_STEP_CYC = CYCLE_STEP_US * CYC_PER_US;
	// ==========================================================
	// zone set selection sizes, limits and widths
	localparam int unsigned SEL_IN_BASIC = 6;
	localparam int unsigned SEL_IN_EXT = 8;
	localparam int unsigned SETS_BASIC = 20;
	localparam int unsigned SETS_EXT = 70;
	localparam int unsigned WARN_MAX = 2;
	localparam int unsigned FAULT_LIMIT = 5;
	localparam int unsigned CODE_W = 2;
	localparam int unsigned SET_W = 7;
	localparam int unsigned CNT_W = 28;
	localparam int unsigned WIN_W = 35;
	localparam logic [SET_W-1:0] SET_NONE = 7'h7f;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		SOS_OFF = 3'b000,
		SOS_ON = 3'b001,
		SOS_REST = 3'b011,
		SOS_ERR = 3'b010
	} sos_state_e;
	// per-set zone evaluation from the optical core
	typedef struct packed {
		logic safety_hit;
		logic [WARN_MAX-1:0] warn_hit;
		logic [WARN_MAX-1:0] warn_used;
	} sos_zone_s;
	// static configuration
	typedef struct packed {
		logic ext_conn;
		logic auto_start;
		logic auto_reset_en;
		logic fb_en1;
		logic fb_en2;
		logic alarm_sel;
		logic [WARN_MAX-1:0] warn_act_high;
		logic [CODE_W-1:0] code;
	} sos_cfg_s;
endpackage

// ### core/sos_press_timer.sv
// sos_press_timer: debounces one pushbutton and measures press length.
// assumes the button input is already synchronous to mclk_i.
`timescale 1ns/10ps
module sos_press_timer
	import sos_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// button
	input wire logic button_i,
	// debounced level, running hold count, release pulse with length
	output logic level_o,
	output logic [CNT_W-1:0] hold_o,
	output logic release_o,
	output logic [CNT_W-1:0] length_o
);
	// ==========================================================
	// debounce and hold counter
	logic sync_reg, sync_next;
	logic level_reg, level_next;
	logic [CNT_W-1:0] deb_reg, deb_next;
	logic [CNT_W-1:0] hold_reg, hold_next;
	logic rel_reg, rel_next;
	logic [CNT_W-1:0] len_reg, len_next;

	// a level must stay stable for the debounce time to be taken
	always_comb begin
		sync_next = button_i;
		level_next = level_reg;
		deb_next = '0;
		hold_next = hold_reg;
		rel_next = 1'b0;
		len_next = len_reg;
		if (sync_reg != level_reg) begin
			deb_next = deb_reg + CNT_W'(1);
			if (deb_reg == CNT_W'(DEBOUNCE_CYC - 1)) begin
				level_next = sync_reg;
				deb_next = '0;
			end
		end
		if (level_reg) begin
			// saturate so a stuck button never wraps into the window
			if (hold_reg != '1)
				hold_next = hold_reg + CNT_W'(1);
		end else begin
			hold_next = '0;
		end
		if (level_reg && !level_next) begin
			rel_next = 1'b1;
			len_next = hold_reg;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			sync_reg <= 1'b0;
			level_reg <= 1'b0;
			deb_reg <= '0;
			hold_reg <= '0;
			rel_reg <= 1'b0;
			len_reg <= '0;
		end else begin
			sync_reg <= sync_next;
			level_reg <= level_next;
			deb_reg <= deb_next;
			hold_reg <= hold_next;
			rel_reg <= rel_next;
			len_reg <= len_next;
		end
	end

	assign level_o = level_reg;
	assign hold_o = hold_reg;
	assign release_o = rel_reg;
	assign length_o = len_reg;
endmodule

// ### tb/sos_monitor.sv
// sos_monitor: port-level checks of the safety output supervisor.
// assumes it is bound onto sos_supervisor; one clock domain only.
`timescale 1ns/10ps
module sos_monitor
	import sos_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// watched inputs
	input wire sos_cfg_s cfg_i,
	input wire sos_zone_s zone_i,
	input wire logic zone_valid_i,
	input wire logic wiring_ok_i,
	input wire logic fault_i,
	input wire logic test_pulse_fault_i,
	// watched outputs
	input wire logic [1:0] safety_switch_output_o,
	input wire logic alarm_o,
	input wire logic [SET_W-1:0] active_set_o,
	input wire logic set_error_o,
	input wire logic auto_reset_lock_o,
	input wire logic [2:0] state_o
);
	// ==========
	// properties
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// a violated safety zone reported by the optical core
	sequence hit_s;
		zone_valid_i && zone_i.safety_hit;
	endsequence
	// two-edge forms skip the edge where state and outputs both move
	sequence err_s;
		state_o == SOS_ERR ##1 state_o == SOS_ERR;
	endsequence
	sequence rest_s;
		state_o == SOS_REST ##1 state_o == SOS_REST;
	endsequence
	hit_off_a: assert property (hit_s |-> ##[1:2]
		safety_switch_output_o == 2'h0) else $error("on after zone hit");
	pair_same_a: assert property (safety_switch_output_o != 2'h1 &&
		safety_switch_output_o != 2'h2) else $error("output pair split");
	on_cause_a: assert property ($rose(safety_switch_output_o[0]) |->
		$past(wiring_ok_i) && !$past(fault_i)) else $error("bad start");
	err_off_a: assert property (err_s |->
		safety_switch_output_o == 2'h0) else $error("on in error");
	rest_off_a: assert property (rest_s |->
		safety_switch_output_o == 2'h0) else $error("on in rest");
	pulse_err_a: assert property (state_o == SOS_ON &&
		test_pulse_fault_i |-> ##[1:2] state_o == SOS_ERR)
		else $error("pulse fault missed");
	set_flag_a: assert property (set_error_o ==
		(active_set_o == SET_NONE)) else $error("set flag wrong");
	set_change_a: assert property ($changed(active_set_o) |->
		safety_switch_output_o == 2'h0) else $error("on across set change");
	alarm_ext_a: assert property (cfg_i.ext_conn &&
		$past(cfg_i.ext_conn) |-> !alarm_o) else $error("alarm in extended");
	lock_hold_a: assert property (auto_reset_lock_o |=>
		auto_reset_lock_o) else $error("lock dropped");
endmodule
bind sos_supervisor sos_monitor u_mon (.mclk_i, .reset_n_i, .cfg_i,
	.zone_i, .zone_valid_i, .wiring_ok_i, .fault_i, .test_pulse_fault_i,
	.safety_switch_output_o, .alarm_o, .active_set_o, .set_error_o,
	.auto_reset_lock_o, .state_o);

// ### tb/sos_contactor.sv
// sos_contactor: two contactors with normally closed feedback contacts.
// assumes the bench picks a prompt or a slow contact travel time.
`timescale 1ns/10ps
module sos_contactor (
	// clock
	input wire logic mclk_i,
	// coil drive and travel speed
	input wire logic [1:0] coil_i,
	input wire logic slow_i,
	// feedback, 1 = circuit open
	output logic [1:0] fb_o
);
	// ==========
	// travel
	int cnt [2] = '{0, 0};
	// single driver for the feedback pins, closed at power-up
	logic [1:0] fb_reg = 2'h0;
	assign fb_o = fb_reg;
	// contacts lag the coil, well inside the pull-in and drop-out limits
	always @(posedge mclk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (fb_reg[i] === coil_i[i]) begin
				cnt[i] <= 0;
			end else if (cnt[i] >= (slow_i ? 40 : 3)) begin
				fb_reg[i] <= coil_i[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule

// ### tb/tb.sv
// tb: self-checking bench for the safety output supervisor.
// assumes 20 MHz, shortened auto reset and fault window.
`timescale 1ns/10ps
module tb
	import sos_pkg::*;
;
	// ==========
	// signals
	logic mclk_i, reset_n_i, start_btn_i, reset_btn_i, rest_req_i, slow;
	logic zone_valid_i, wiring_ok_i, fault_i, test_pulse_fault_i;
	logic interface_fault_code_i, window_dirty_warning_i;
	sos_cfg_s cfg_i;
	sos_zone_s zone_i;
	logic [SETS_EXT-1:0][SEL_IN_EXT-1:0] set_pattern_i;
	logic [SETS_EXT-1:0] set_valid_i;
	logic [SEL_IN_EXT-1:0] ctrl_in_i;
	logic [1:0] contactor_feedback_monitor_i, safety_switch_output_o;
	logic [WARN_MAX-1:0] warn_o;
	logic [SET_W-1:0] active_set_o;
	logic [2:0] state_o;
	logic alarm_o, set_error_o, cycle_tick_o, auto_reset_lock_o;
	int miscompares = 0, checks = 0, v = 0;
	typedef struct {int k; logic [7:0] v;} sos_note_s;
	sos_note_s notes [$];
	string names [8] = '{"state", "outputs", "set", "warn", "alarm", "lock",
		"ticks", "set_error"};
	localparam int ST = 0, SO = 1, AS = 2, WN = 3, AL = 4, LK = 5, TK = 6;
	localparam int SE = 7;
	int ticks = 0;
	event look;
	sos_supervisor #(.AUTO_RESET_CYCLES(100), .FAULT_WINDOW_CYCLES(1000))
	DUT (.mclk_i, .reset_n_i, .cfg_i, .set_pattern_i, .set_valid_i,
		.ctrl_in_i, .start_btn_i, .reset_btn_i, .rest_req_i, .zone_i,
		.zone_valid_i, .wiring_ok_i, .fault_i, .test_pulse_fault_i,
		.interface_fault_code_i, .window_dirty_warning_i,
		.contactor_feedback_monitor_i, .safety_switch_output_o, .warn_o,
		.alarm_o, .active_set_o, .set_error_o, .cycle_tick_o,
		.auto_reset_lock_o, .state_o);
	sos_contactor u_ctr (.mclk_i, .coil_i(safety_switch_output_o),
		.slow_i(slow), .fb_o(contactor_feedback_monitor_i));
	// clock
	initial begin
		mclk_i = 1'h0;
		forever #25 mclk_i = ~mclk_i;
	end
	// measurement cycle ticks; even code 0 is far longer than this run
	always @(posedge mclk_i)
		if (cycle_tick_o === 1'b1)
			ticks++;
	// ==========
	// tasks
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask
	task automatic chk(int k, logic [7:0] e);
		notes.push_back('{k, e});
		->look;
	endtask
	// long wait first so a slow contactor has closed before a start
	task automatic zv(logic hit, logic [1:0] w);
		cyc(45);
		zone_i = '{hit, w, 2'h3};
		zone_valid_i = 1'h1;
		cyc(1);
		zone_valid_i = 1'h0;
		cyc(2);
	endtask
	task automatic cmp(string nm, logic [7:0] seen, logic [7:0] e);
		checks++;
		if (seen !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// the oldest note is compared with the output it names
	always @(look) begin
		sos_note_s n;
		logic [7:0] seen [8];
		while (notes.size() > 0) begin
			n = notes.pop_front();
			seen = '{8'(state_o), 8'(safety_switch_output_o),
				8'(active_set_o), 8'(warn_o), 8'(alarm_o), 8'(auto_reset_lock_o),
				8'((ticks > 255) ? 255 : ticks), 8'(set_error_o)};
			cmp(names[n.k], seen[n.k], n.v);
		end
	end
	// hang guard, sized above the two 21000-cycle button presses
	initial begin
		#(100000 * 50);
		miscompares++;
		conclude();
	end
	// ==========
	// scenarios
	initial begin
		void'($urandom(32'h1dda));
		{reset_n_i, start_btn_i, reset_btn_i, rest_req_i, zone_valid_i,
			fault_i, test_pulse_fault_i, interface_fault_code_i,
			window_dirty_warning_i, slow} = '0;
		wiring_ok_i = 1'h1;
		cfg_i = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h1, 2'($urandom)};
		zone_i = '0;
		ctrl_in_i = 8'h0;
		set_valid_i = '1;
		for (int i = 0; i < SETS_EXT; i++) set_pattern_i[i] = 8'(i);
		cyc(4);
		reset_n_i = 1'h1;
		// power-up start is automatic even in manual mode
		zv(1'h0, 2'h0);
		chk(ST, 8'(SOS_ON));
		chk(SO, 8'h3);
		chk(AS, 8'h0);
		chk(SE, 8'h0);
		// warning bit 0 is active high, bit 1 active low
		zv(1'h0, 2'h3);
		chk(WN, 8'h1);
		zv(1'h1, 2'h0);
		chk(WN, 8'h2);
		chk(SO, 8'h0);
		// manual mode: free zone and a short press do not restart
		zv(1'h0, 2'h0);
		chk(SO, 8'h0);
		start_btn_i = 1'h1;
		cyc(21000);
		start_btn_i = 1'h0;
		cyc(21000);
		zv(1'h0, 2'h0);
		chk(SO, 8'h0);
		cfg_i.auto_start = 1'h1;
		wiring_ok_i = 1'h0;
		zv(1'h0, 2'h0);
		chk(SO, 8'h0);
		wiring_ok_i = 1'h1;
		slow = 1'h1;
		zv(1'h0, 2'h0);
		chk(SO, 8'h3);
		// random set changes, upper two inputs masked in basic mode
		repeat (4) begin
			v = (v + 1 + $urandom_range(18)) % 20;
			ctrl_in_i = {2'($urandom), 6'(v)};
			cyc(2);
			chk(AS, 8'(v));
			chk(SO, 8'h0);
			zv(1'h0, 2'h0);
			chk(SO, 8'h3);
		end
		ctrl_in_i = 8'h3f;
		cyc(2);
		chk(AS, 8'h7f);
		chk(SE, 8'h1);
		cfg_i.ext_conn = 1'h1;
		window_dirty_warning_i = 1'h1;
		cyc(2);
		chk(AS, 8'h3f);
		chk(AL, 8'h0);
		ctrl_in_i = 8'h45;
		cyc(2);
		chk(AS, 8'h45);
		{cfg_i.ext_conn, cfg_i.alarm_sel, ctrl_in_i} = 10'h0;
		cyc(2);
		chk(AL, 8'h1);
		window_dirty_warning_i = 1'h0;
		cfg_i.alarm_sel = 1'h1;
		zv(1'h0, 2'h0);
		chk(SO, 8'h3);
		// output test pulse fault, then automatic recovery
		test_pulse_fault_i = 1'h1;
		cyc(1);
		test_pulse_fault_i = 1'h0;
		cyc(2);
		chk(ST, 8'(SOS_ERR));
		chk(AL, 8'h1);
		cyc(80);
		chk(SO, 8'h0);
		chk(ST, 8'(SOS_ERR));
		cyc(30);
		// automatic start follows the recovery at once
		chk(ST, 8'(SOS_ON));
		// buttons cannot leave error; short reset press refused
		cfg_i.auto_reset_en = 1'h0;
		fault_i = 1'h1;
		cyc(2);
		fault_i = 1'h0;
		{start_btn_i, reset_btn_i} = 2'h3;
		cyc(21000);
		{start_btn_i, reset_btn_i} = 2'h0;
		cyc(21000);
		chk(ST, 8'(SOS_ERR));
		cfg_i.auto_reset_en = 1'h1;
		cyc(1);
		chk(ST, 8'(SOS_OFF));
		rest_req_i = 1'h1;
		cyc(2);
		chk(ST, 8'(SOS_REST));
		zv(1'h0, 2'h3);
		chk(SO, 8'h0);
		chk(WN, 8'h2);
		rest_req_i = 1'h0;
		// off lasts one cycle before the automatic start
		cyc(1);
		chk(ST, 8'(SOS_OFF));
		zv(1'h0, 2'h0);
		chk(SO, 8'h3);
		// six interface faults inside the window lock auto reset
		repeat (6) begin
			interface_fault_code_i = 1'h1;
			cyc(2);
			interface_fault_code_i = 1'h0;
			cyc(105);
		end
		chk(LK, 8'h1);
		cyc(200);
		chk(ST, 8'(SOS_ERR));
		chk(TK, 8'h0);
		// let the compare process drain the last notes
		cyc(1);
		conclude();
	end
endmodule
